// [hdl/tlc_ctrl.v]
/*
 * two level cache control: registers, cache tags, partition, maintenance.
 * assumes indexed cpu and io register ports; fills and maintenance are
 * done by the memory side, which answers with done and ready.
 */
`timescale 1ns/10ps
`include "tlc_defines.vh"

//Contract
//RULE1: icache always direct mapped, 4KB, 64 byte lines, whole line fills.
//RULE2: icache hits give one access per cycle.
//RULE3: dcache 4KB, two way, 32 byte lines, single cycle hits.
//RULE4: dcache can never become addressed sram.
//RULE5: dcache caches second level space and cacheable external regions only.
//RULE6: dcache victim chosen least recently used of two ways.
//RULE7: second level 64KB unified, quarters split between cache and sram.
//RULE8: each cache quarter adds one way, four ways when all cache.
//RULE9: only the cpu writes control registers; io only reads them.
//RULE10: low three config bits pick partition, reset 000, 100-110 reserved.
//RULE11: four range operations, each with own base and count registers.
//RULE12: clean command cleans all cache lines, leaves sram alone.
//RULE13: flush command flushes all cache contents, not sram.
//RULE14: indexed region attributes mark external spaces cacheable.
//RULE15: icache address is 20 bit tag, 6 bit set, 6 bit offset.
//RULE16: io subsystem writes are ignored and start nothing.
//RULE17: reserved partition code write keeps previous partition.
module tlc_ctrl #(
    parameter [15:0] L2_SPACE_HI = 16'h0000,
    parameter L2_LINE_B = 128,
    parameter L2_SETS = 128
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire cpu_reg_wr,
    input wire [4:0] cpu_reg_idx,
    input wire [31:0] cpu_reg_wdata,
    output reg [31:0] cpu_reg_rdata_q,
    input wire io_reg_wr,
    input wire [4:0] io_reg_idx,
    input wire [31:0] io_reg_wdata,
    output reg [31:0] io_reg_rdata_q,
    input wire fetch_valid,
    input wire [31:0] fetch_addr,
    output reg fetch_hit_q,
    output reg fetch_miss_q,
    output reg [31:0] ifill_addr_q,
    input wire ifill_done,
    input wire data_valid,
    input wire [31:0] data_addr,
    output wire data_hit,
    output wire data_miss,
    output reg data_uncached_q,
    input wire dfill_done,
    input wire [31:0] dfill_addr,
    output wire maint_valid,
    input wire maint_ready,
    output reg [2:0] maint_kind_q,
    output reg [31:0] maint_addr_q,
    output reg [1:0] maint_way_q,
    output wire [3:0] l2_way_en,
    output wire busy
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RANGE = 2'h1;
    localparam ST_SWEEP = 2'h2;
    localparam integer SET_LAST = L2_SETS - 1;

    reg [2:0] mode_q;
    reg [31:0] base_q [0:3];
    reg [31:0] cnt_q [0:3];
    reg [31:0] attr_q [0:15];
    reg [1:0] st_q;
    reg [31:0] rem_q; // bytes still to cover
    reg [7:0] set_q;
    reg [19:0] itag [0:63];
    reg [63:0] iv_q;
    integer k;

    // cache quarters enabled by the partition code [RULE8]
    function [3:0] ways_of;
        input [2:0] m;
        begin
            case (m)
                `TLC_MODE_Q1: ways_of = 4'h1;
                `TLC_MODE_Q2: ways_of = 4'h3;
                `TLC_MODE_Q3: ways_of = 4'h7;
                `TLC_MODE_ALL: ways_of = 4'hf;
                default: ways_of = 4'h0;
            endcase
        end
    endfunction

    // reserved codes 100 to 110 are not accepted [RULE10]
    function legal_mode;
        input [2:0] m;
        begin
            legal_mode = m <= `TLC_MODE_Q3 || m == `TLC_MODE_ALL;
        end
    endfunction

    // register read shared by both ports
    function [31:0] read_reg;
        input [4:0] idx;
        begin
            if (idx[`TLC_IDX_ATTR_BIT])
                read_reg = {31'h0, attr_q[idx[3:0]][0]};
            else if (idx == `TLC_IDX_CFG)
                read_reg = {busy, 28'h0, mode_q};
            else if (idx >= `TLC_IDX_WB_BASE && idx <= `TLC_IDX_DF_CNT)
                read_reg = idx[0] ? base_q[idx[2:1]] : cnt_q[idx[2:1] - 2'h1];
            else if (idx == `TLC_IDX_CLEAN || idx == `TLC_IDX_FLUSH)
                read_reg = {31'h0, busy};
            else
                read_reg = 32'h0;
        end
    endfunction

    // step of each range kind: instruction line or data line
    function [31:0] step_of;
        input [2:0] kd;
        begin
            step_of = (kd == `TLC_K_II) ? `TLC_I_LINE_B : `TLC_D_LINE_B;
        end
    endfunction

    assign l2_way_en = ways_of(mode_q); // [RULE7]
    assign busy = st_q != ST_IDLE;
    assign maint_valid = busy;

    // decode of cpu writes; io writes never reach this [RULE9] [RULE16]
    wire wr_cnt = cpu_reg_wr && !cpu_reg_idx[`TLC_IDX_ATTR_BIT] && cpu_reg_idx != 5'h0
        && cpu_reg_idx <= `TLC_IDX_DF_CNT && !cpu_reg_idx[0];
    wire [1:0] wr_op = cpu_reg_idx[2:1] - 2'h1;
    wire wr_sweep = cpu_reg_wr && (cpu_reg_idx == `TLC_IDX_CLEAN ||
        cpu_reg_idx == `TLC_IDX_FLUSH) && cpu_reg_wdata[0];
    wire [31:0] wr_bytes = {cpu_reg_wdata[29:0], 2'h0}; // word count to bytes

    // control registers, writable by the cpu only [RULE9]
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= `TLC_MODE_RST; // [RULE10]
            for (k = 0; k < 4; k = k + 1) begin
                base_q[k] <= 32'h0;
                cnt_q[k] <= 32'h0;
            end
            for (k = 0; k < 16; k = k + 1)
                attr_q[k] <= 32'h0;
            cpu_reg_rdata_q <= 32'h0;
            io_reg_rdata_q <= 32'h0;
        end else if (ce) begin
            cpu_reg_rdata_q <= read_reg(cpu_reg_idx);
            io_reg_rdata_q <= read_reg(io_reg_idx); // read only view [RULE9]
            if (cpu_reg_wr) begin
                if (cpu_reg_idx[`TLC_IDX_ATTR_BIT])
                    attr_q[cpu_reg_idx[3:0]] <= {31'h0, cpu_reg_wdata[0]}; // [RULE14]
                else if (cpu_reg_idx == `TLC_IDX_CFG) begin
                    if (legal_mode(cpu_reg_wdata[`TLC_MODE_MSB:0]))
                        mode_q <= cpu_reg_wdata[`TLC_MODE_MSB:0]; // else kept [RULE17]
                end else if (wr_cnt)
                    cnt_q[wr_op] <= cpu_reg_wdata;
                else if (cpu_reg_idx >= `TLC_IDX_WB_BASE && cpu_reg_idx <= `TLC_IDX_DF_CNT)
                    base_q[cpu_reg_idx[2:1]] <= cpu_reg_wdata;
            end
        end
    end

    // maintenance: count write walks a range, clean/flush sweep cache ways
    // only, never sram quarters; requests while busy are dropped
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            rem_q <= 32'h0;
            set_q <= 8'h0;
            maint_kind_q <= `TLC_K_WB;
            maint_addr_q <= 32'h0;
            maint_way_q <= 2'h0;
        end else if (ce) begin
            case (st_q)
                ST_IDLE: begin
                    if (wr_cnt && cpu_reg_wdata != 32'h0) begin
                        st_q <= ST_RANGE; // [RULE11]
                        maint_kind_q <= {1'b0, wr_op};
                        maint_addr_q <= base_q[wr_op] & ~(step_of({1'b0, wr_op}) - 32'h1);
                        rem_q <= wr_bytes;
                        maint_way_q <= 2'h0;
                    end else if (wr_sweep && l2_way_en != 4'h0) begin
                        st_q <= ST_SWEEP; // [RULE12] [RULE13]
                        maint_kind_q <= (cpu_reg_idx == `TLC_IDX_CLEAN) ?
                            `TLC_K_CLEAN : `TLC_K_FLUSH;
                        maint_addr_q <= 32'h0;
                        set_q <= 8'h0;
                        maint_way_q <= 2'h0;
                    end
                end
                ST_RANGE: begin
                    if (maint_ready) begin
                        maint_addr_q <= maint_addr_q + step_of(maint_kind_q);
                        if (rem_q <= step_of(maint_kind_q)) begin
                            rem_q <= 32'h0;
                            st_q <= ST_IDLE;
                        end else
                            rem_q <= rem_q - step_of(maint_kind_q);
                    end
                end
                ST_SWEEP: begin
                    if (maint_ready) begin
                        if ({24'h0, set_q} != SET_LAST) begin
                            set_q <= set_q + 8'h1;
                            maint_addr_q <= maint_addr_q + L2_LINE_B;
                        end else begin
                            set_q <= 8'h0;
                            maint_addr_q <= 32'h0;
                            // next way only while it is a cache quarter [RULE12] [RULE13]
                            if (maint_way_q == 2'h3 || !l2_way_en[maint_way_q + 2'h1])
                                st_q <= ST_IDLE;
                            else
                                maint_way_q <= maint_way_q + 2'h1;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // instruction cache: fixed direct mapped, no sram mode [RULE1] [RULE15]
    wire [5:0] fset = fetch_addr[`TLC_I_SET_MSB:`TLC_I_SET_LSB];
    wire [19:0] ftag = fetch_addr[31:`TLC_I_TAG_LSB];
    wire [5:0] fill_set = ifill_addr_q[`TLC_I_SET_MSB:`TLC_I_SET_LSB];
    wire [5:0] iinv_set = maint_addr_q[`TLC_I_SET_MSB:`TLC_I_SET_LSB];
    wire iinv = busy && maint_ready && maint_kind_q == `TLC_K_II;
    wire ihit = iv_q[fset] && itag[fset] == ftag;

    // one lookup per cycle; a miss latches the whole line address [RULE2]
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            iv_q <= 64'h0;
            fetch_hit_q <= 1'b0;
            fetch_miss_q <= 1'b0;
            ifill_addr_q <= 32'h0;
        end else if (ce) begin
            fetch_hit_q <= fetch_valid && ihit; // [RULE2]
            fetch_miss_q <= fetch_valid && !ihit;
            if (fetch_valid && !ihit)
                ifill_addr_q <= {fetch_addr[31:`TLC_I_SET_LSB], 6'h0}; // whole line [RULE1]
            if (iinv && itag[iinv_set] == maint_addr_q[31:`TLC_I_TAG_LSB])
                iv_q[iinv_set] <= 1'b0;
            // fill after the invalidate so a completing fill is kept
            if (ifill_done) begin
                itag[fill_set] <= ifill_addr_q[31:`TLC_I_TAG_LSB];
                iv_q[fill_set] <= 1'b1;
            end
        end
    end

    // cacheable: second level space or an external region marked so [RULE5]
    wire in_l2 = data_addr[`TLC_L2_HI_MSB:`TLC_L2_HI_LSB] == L2_SPACE_HI;
    wire cacheable = in_l2 || attr_q[data_addr[`TLC_RGN_MSB:`TLC_RGN_LSB]][0]; // [RULE14]
    wire dinv = busy && maint_ready &&
        (maint_kind_q == `TLC_K_WBI || maint_kind_q == `TLC_K_DF);

    always @(posedge clk or posedge rst) begin
        if (rst)
            data_uncached_q <= 1'b0;
        else if (ce)
            data_uncached_q <= data_valid && !cacheable; // goes straight to memory
    end

    // data cache tags; always a cache, nothing maps it as sram [RULE4]
    tlc_l1d_tags u_l1d (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .lk_valid(data_valid),
        .lk_addr(data_addr),
        .lk_cacheable(cacheable),
        .hit_q(data_hit),
        .miss_q(data_miss),
        .fill_done(dfill_done),
        .fill_addr(dfill_addr),
        .inv_valid(dinv),
        .inv_addr(maint_addr_q)
    );
endmodule // tlc_ctrl

// [common/tlc_defines.vh]
/*
 * constants of the two level cache controller: register indices,
 * field positions, partition codes, maintenance kinds, address splits.
 * assumes inclusion by bare name, no processes here.
 */
`ifndef TLC_DEFINES_VH
`define TLC_DEFINES_VH

// register indices on the control register port
`define TLC_IDX_CFG 5'h00
`define TLC_IDX_WB_BASE 5'h01
`define TLC_IDX_WB_CNT 5'h02
`define TLC_IDX_WBI_BASE 5'h03
`define TLC_IDX_WBI_CNT 5'h04
`define TLC_IDX_II_BASE 5'h05
`define TLC_IDX_II_CNT 5'h06
`define TLC_IDX_DF_BASE 5'h07
`define TLC_IDX_DF_CNT 5'h08
`define TLC_IDX_CLEAN 5'h09
`define TLC_IDX_FLUSH 5'h0a
`define TLC_IDX_ATTR_BIT 4

// partition field and its codes
`define TLC_MODE_MSB 2
`define TLC_MODE_RST 3'h0
`define TLC_MODE_Q1 3'h1
`define TLC_MODE_Q2 3'h2
`define TLC_MODE_Q3 3'h3
`define TLC_MODE_ALL 3'h7
`define TLC_BUSY_BIT 31

// maintenance kinds
`define TLC_K_WB 3'h0
`define TLC_K_WBI 3'h1
`define TLC_K_II 3'h2
`define TLC_K_DF 3'h3
`define TLC_K_CLEAN 3'h4
`define TLC_K_FLUSH 3'h5

// first level instruction cache split: tag 20, set 6, offset 6
`define TLC_I_TAG_LSB 12
`define TLC_I_SET_MSB 11
`define TLC_I_SET_LSB 6
`define TLC_I_LINE_B 32'h40
// first level data cache split: 64 sets of 2 ways, 32 byte lines
`define TLC_D_TAG_LSB 11
`define TLC_D_SET_MSB 10
`define TLC_D_SET_LSB 5
`define TLC_D_LINE_B 32'h20

// second level space and external region select
`define TLC_L2_HI_MSB 31
`define TLC_L2_HI_LSB 16
`define TLC_RGN_MSB 27
`define TLC_RGN_LSB 24
`define TLC_WORD_B 32'h4

`endif

// [hdl/tlc_l1d_tags.v]
/*
 * tag store of the first level data cache: 64 sets, two ways, lru.
 * assumes the fill engine outside answers a miss with fill_done.
 */
`timescale 1ns/10ps
`include "tlc_defines.vh"

module tlc_l1d_tags (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire lk_valid,
    input wire [31:0] lk_addr,
    input wire lk_cacheable,
    output reg hit_q,
    output reg miss_q,
    input wire fill_done,
    input wire [31:0] fill_addr,
    input wire inv_valid,
    input wire [31:0] inv_addr
);
    reg [20:0] tag0 [0:63];
    reg [20:0] tag1 [0:63];
    reg [63:0] v0_q;
    reg [63:0] v1_q;
    reg [63:0] lru_q; // way to evict next per set
    wire [5:0] ls = lk_addr[`TLC_D_SET_MSB:`TLC_D_SET_LSB];
    wire [5:0] fs = fill_addr[`TLC_D_SET_MSB:`TLC_D_SET_LSB];
    wire [5:0] is = inv_addr[`TLC_D_SET_MSB:`TLC_D_SET_LSB];
    wire [20:0] lt = lk_addr[31:`TLC_D_TAG_LSB];
    wire [20:0] ft = fill_addr[31:`TLC_D_TAG_LSB];
    wire [20:0] it = inv_addr[31:`TLC_D_TAG_LSB];
    wire h0 = v0_q[ls] && tag0[ls] == lt;
    wire h1 = v1_q[ls] && tag1[ls] == lt;
    // invalid way first, else the least recently used one
    wire fw = !v0_q[fs] ? 1'b0 : (!v1_q[fs] ? 1'b1 : lru_q[fs]); // [RULE6]

    // lookups complete in one cycle, one per cycle [RULE3]
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            v0_q <= 64'h0;
            v1_q <= 64'h0;
            lru_q <= 64'h0;
            hit_q <= 1'b0;
            miss_q <= 1'b0;
        end else if (ce) begin
            hit_q <= lk_valid && lk_cacheable && (h0 || h1);
            miss_q <= lk_valid && lk_cacheable && !(h0 || h1); // [RULE5]
            if (lk_valid && lk_cacheable && (h0 || h1))
                lru_q[ls] <= h0; // used way becomes most recent [RULE6]
            // invalidate first, so a fill on the same bit this cycle wins
            if (inv_valid) begin
                if (v0_q[is] && tag0[is] == it)
                    v0_q[is] <= 1'b0;
                if (v1_q[is] && tag1[is] == it)
                    v1_q[is] <= 1'b0;
            end
            if (fill_done) begin
                if (fw) begin
                    tag1[fs] <= ft;
                    v1_q[fs] <= 1'b1;
                end else begin
                    tag0[fs] <= ft;
                    v0_q[fs] <= 1'b1;
                end
                lru_q[fs] <= ~fw;
            end
        end
    end
endmodule // tlc_l1d_tags

// [tb/tlc_ctrl_props.sv]
/* port checker of tlc_ctrl, bound to every instance of it.
   assumes ce is low only while the block is idle. */
`timescale 1ns/10ps
`include "tlc_defines.vh"
module tlc_ctrl_props #(
    parameter [15:0] L2_SPACE_HI = 16'h0000
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire cpu_reg_wr,
    input wire [4:0] cpu_reg_idx,
    input wire [31:0] cpu_reg_wdata,
    input wire io_reg_wr,
    input wire fetch_valid,
    input wire [31:0] fetch_addr,
    input wire fetch_hit_q,
    input wire fetch_miss_q,
    input wire [31:0] ifill_addr_q,
    input wire data_valid,
    input wire [31:0] data_addr,
    input wire data_hit,
    input wire data_miss,
    input wire data_uncached_q,
    input wire maint_valid,
    input wire maint_ready,
    input wire [2:0] maint_kind_q,
    input wire [31:0] maint_addr_q,
    input wire [1:0] maint_way_q,
    input wire [3:0] l2_way_en,
    input wire busy
);
    // cache quarters of a legal code
    function automatic [3:0] ways(input [2:0] m);
        ways = (m == 3'h7) ? 4'hf : (4'hf >> (3'h4 - m));
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // shared request steps
    sequence s_cfg_wr;
        ce && cpu_reg_wr && cpu_reg_idx == `TLC_IDX_CFG;
    endsequence
    sequence s_sweep_wr;
        ce && cpu_reg_wr && cpu_reg_wdata[0] && cpu_reg_idx inside {`TLC_IDX_CLEAN, `TLC_IDX_FLUSH};
    endsequence
    a_mode_ways: assert property (s_cfg_wr ##0 cpu_reg_wdata[2:0] inside {[0:3], 7} |=>
        l2_way_en == ways($past(cpu_reg_wdata[2:0]))) else $error("way enables off mode");
    a_reserved_kept: assert property (s_cfg_wr ##0 cpu_reg_wdata[2:0] inside {[4:6]} |=>
        $stable(l2_way_en)) else $error("reserved code changed partition");
    a_io_ignored: assert property (ce && io_reg_wr && !cpu_reg_wr && !busy |=>
        $stable(l2_way_en) && !busy) else $error("io write had an effect");
    a_fetch_answer: assert property (ce && fetch_valid |=> fetch_hit_q != fetch_miss_q)
        else $error("fetch not answered next cycle");
    a_miss_line: assert property (ce && fetch_valid ##1 fetch_miss_q |->
        ifill_addr_q == {$past(fetch_addr[31:6]), 6'h00}) else $error("bad fill line");
    a_l2_data: assert property (ce && data_valid && data_addr[31:16] == L2_SPACE_HI |=>
        data_hit != data_miss && !data_uncached_q) else $error("l2 space not cached");
    a_maint_hold: assert property (maint_valid && !maint_ready |=>
        maint_valid && $stable(maint_addr_q) && $stable(maint_kind_q)) else $error("request moved");
    a_sweep_cache: assert property (maint_valid && maint_kind_q >= `TLC_K_CLEAN |->
        l2_way_en[maint_way_q]) else $error("sweep touched sram quarter");
    a_clean_nosram: assert property (s_sweep_wr ##0 l2_way_en == 4'h0 && !busy |=>
        !busy [*2]) else $error("sweep started with no cache");
    a_busy_bound: assert property ($rose(busy) |-> ##[1:1000] !busy)
        else $error("maintenance never ended");
endmodule // tlc_ctrl_props

bind tlc_ctrl tlc_ctrl_props #(.L2_SPACE_HI(L2_SPACE_HI)) u_tlc_ctrl_props (.clk(clk),
    .rst(rst), .ce(ce), .cpu_reg_wr(cpu_reg_wr), .cpu_reg_idx(cpu_reg_idx),
    .cpu_reg_wdata(cpu_reg_wdata), .io_reg_wr(io_reg_wr), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_hit_q(fetch_hit_q), .fetch_miss_q(fetch_miss_q),
    .ifill_addr_q(ifill_addr_q), .data_valid(data_valid), .data_addr(data_addr),
    .data_hit(data_hit), .data_miss(data_miss), .data_uncached_q(data_uncached_q),
    .maint_valid(maint_valid), .maint_ready(maint_ready), .maint_kind_q(maint_kind_q),
    .maint_addr_q(maint_addr_q), .maint_way_q(maint_way_q), .l2_way_en(l2_way_en),
    .busy(busy));

// [tb/tlc_mem_model.sv]
/* memory side model: answers line fills and maintenance requests.
   assumes design outputs settle after the rising edge. */
`timescale 1ns/10ps
module tlc_mem_model (
    input wire clk,
    input wire rst,
    input wire slow,
    input wire fetch_miss_q,
    input wire data_valid,
    input wire [31:0] data_addr,
    input wire data_miss,
    input wire maint_valid,
    output reg ifill_done,
    output reg dfill_done,
    output reg [31:0] dfill_addr,
    output reg maint_ready
);
    reg [31:0] last_q;
    reg [2:0] iwait_q, dwait_q;
    reg tog_q;
    // lookup address that a miss will refer to
    always @(posedge clk) if (data_valid) last_q <= data_addr;
    // answers change after the falling edge, slow mode stretches them
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            ifill_done <= 1'b0;
            dfill_done <= 1'b0;
            dfill_addr <= 32'h0;
            maint_ready <= 1'b0;
            iwait_q <= 3'h0;
            dwait_q <= 3'h0;
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            maint_ready <= maint_valid && (!slow || tog_q); // slow mode stalls every other cycle
            ifill_done <= (iwait_q == 3'h1); // whole line per miss
            iwait_q <= fetch_miss_q ? (slow ? 3'h4 : 3'h1) : iwait_q - (iwait_q != 3'h0);
            dfill_done <= (dwait_q == 3'h1);
            dwait_q <= data_miss ? (slow ? 3'h3 : 3'h1) : dwait_q - (dwait_q != 3'h0);
            if (data_miss) dfill_addr <= last_q;
            else if (dfill_done) dfill_addr <= ~dfill_addr; // no stale address after use
        end
    end
endmodule // tlc_mem_model

// [tb/two_level_cache_control_tb.sv]
/* bench of tlc_ctrl: registers, partitions, both first level caches,
   range and sweep maintenance. assumes the memory model beside it. */
`timescale 1ns/10ps
`include "tlc_defines.vh"
module two_level_cache_control_tb;
    localparam SETS = 4;
    reg clk = 1'b0, rst = 1'b1, ce = 1'b1, slow = 1'b0;
    reg cpu_reg_wr = 1'b0, io_reg_wr = 1'b0, fetch_valid = 1'b0, data_valid = 1'b0;
    reg [4:0] cpu_reg_idx = 5'h00, io_reg_idx = 5'h00;
    reg [31:0] cpu_reg_wdata = 32'h0, io_reg_wdata = 32'h0, fetch_addr = 32'h0;
    reg [31:0] data_addr = 32'h0, a, d, w;
    wire [31:0] cpu_reg_rdata_q, io_reg_rdata_q, ifill_addr_q, dfill_addr, maint_addr_q;
    wire fetch_hit_q, fetch_miss_q, ifill_done, data_hit, data_miss, data_uncached_q;
    wire dfill_done, maint_valid, maint_ready, busy;
    wire [2:0] maint_kind_q;
    wire [1:0] maint_way_q;
    wire [3:0] l2_way_en;
    integer failures = 0, compares = 0, nacc = 0, i, k, n0;
    tlc_ctrl #(.L2_SETS(SETS)) u_tlc_ctrl (.clk(clk), .rst(rst), .ce(ce),
        .cpu_reg_wr(cpu_reg_wr), .cpu_reg_idx(cpu_reg_idx), .cpu_reg_wdata(cpu_reg_wdata),
        .cpu_reg_rdata_q(cpu_reg_rdata_q), .io_reg_wr(io_reg_wr), .io_reg_idx(io_reg_idx),
        .io_reg_wdata(io_reg_wdata), .io_reg_rdata_q(io_reg_rdata_q),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_hit_q(fetch_hit_q),
        .fetch_miss_q(fetch_miss_q), .ifill_addr_q(ifill_addr_q), .ifill_done(ifill_done),
        .data_valid(data_valid), .data_addr(data_addr), .data_hit(data_hit),
        .data_miss(data_miss), .data_uncached_q(data_uncached_q), .dfill_done(dfill_done),
        .dfill_addr(dfill_addr), .maint_valid(maint_valid), .maint_ready(maint_ready),
        .maint_kind_q(maint_kind_q), .maint_addr_q(maint_addr_q),
        .maint_way_q(maint_way_q), .l2_way_en(l2_way_en), .busy(busy));
    tlc_mem_model u_tlc_mem_model (.clk(clk), .rst(rst), .slow(slow),
        .fetch_miss_q(fetch_miss_q), .data_valid(data_valid), .data_addr(data_addr),
        .data_miss(data_miss), .maint_valid(maint_valid), .ifill_done(ifill_done),
        .dfill_done(dfill_done), .dfill_addr(dfill_addr), .maint_ready(maint_ready));
    // clock and accepted maintenance requests
    always #12.5 clk = ~clk;
    always @(posedge clk) if (maint_valid && maint_ready) nacc <= nacc + 1;
    // expected way enables of a legal partition code
    function [3:0] ways_of(input [2:0] m);
        ways_of = (m == 3'h7) ? 4'hf : (4'hf >> (3'h4 - m));
    endfunction
    task report_and_stop;
        begin
            $display("compares %0d failures %0d", compares, failures);
            if (failures == 0 && compares > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // one register write, cpu or io port, idle edge before it
    task wr(input io, input [4:0] idx, input [31:0] v);
        begin
            cyc(1);
            cpu_reg_wr = !io;
            io_reg_wr = io;
            cpu_reg_idx = idx;
            io_reg_idx = idx;
            cpu_reg_wdata = v;
            io_reg_wdata = v;
            cyc(1);
            cpu_reg_wr = 1'b0;
            io_reg_wr = 1'b0;
        end
    endtask
    task rd(input [4:0] idx, input [31:0] e);
        begin
            cpu_reg_idx = idx;
            io_reg_idx = idx;
            cyc(1);
            chk(cpu_reg_rdata_q, e);
            chk(io_reg_rdata_q, e);
        end
    endtask
    // lookups stay requested; answer is read one cycle on
    task fetch(input [31:0] ad, input [1:0] e);
        begin
            fetch_valid = 1'b1;
            fetch_addr = ad;
            cyc(1);
            chk({fetch_hit_q, fetch_miss_q}, e);
        end
    endtask
    task dacc(input [31:0] ad, input [2:0] e);
        begin
            data_valid = 1'b1;
            data_addr = ad;
            cyc(1);
            chk({data_hit, data_miss, data_uncached_q}, e);
        end
    endtask
    task wait_fill(input dsel);
        begin
            fetch_valid = 1'b0;
            data_valid = 1'b0;
            for (k = 0; k < 20 && (dsel ? dfill_done : ifill_done) !== 1'b1; k = k + 1) cyc(1);
            cyc(1);
        end
    endtask
    task wait_idle;
        begin
            for (k = 0; k < 200 && busy !== 1'b0; k = k + 1) cyc(1);
            chk(busy, 1'b0);
        end
    endtask
    task range_op(input [2:0] kd, input [31:0] base, input [31:0] cnt);
        begin
            n0 = nacc;
            wr(1'b0, 5'h01 + {kd, 1'b0}, base);
            wr(1'b0, 5'h02 + {kd, 1'b0}, cnt);
            chk({busy, maint_kind_q}, {1'b1, kd});
            chk(maint_addr_q, base & (kd == `TLC_K_II ? 32'hffff_ffc0 : 32'hffff_ffe0));
            wait_idle;
            rd(5'h02 + {kd, 1'b0}, cnt);
            w = (kd == `TLC_K_II) ? 32'h40 : 32'h20;
            chk(nacc - n0, (cnt * 4 + w - 1) / w);
        end
    endtask
    // hang guard, far beyond the expected few hundred cycles
    initial begin
        #(25 * 20000);
        failures = failures + 1;
        report_and_stop;
    end
    initial begin
        w = $urandom(32'hb0f6);
        cyc(4);
        rst = 1'b0;
        chk(l2_way_en, 4'h0);
        rd(`TLC_IDX_CFG, 32'h0);
        rd(5'h0f, 32'h0);
        ce = 1'b0;
        wr(1'b0, `TLC_IDX_CFG, 32'h7);
        chk(l2_way_en, 4'h0);
        ce = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            wr(1'b0, `TLC_IDX_CFG, 32'h3);
            wr(1'b0, `TLC_IDX_CFG, i);
            chk(l2_way_en, (i > 3 && i < 7) ? 4'h7 : ways_of(i));
            rd(`TLC_IDX_CFG, (i > 3 && i < 7) ? 3 : i);
        end
        wr(1'b1, `TLC_IDX_CFG, 32'h1);
        chk(l2_way_en, 4'hf);
        wr(1'b1, `TLC_IDX_CLEAN, 32'h1);
        chk(busy, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            a = $urandom;
            fetch(a, 2'b01);
            chk(ifill_addr_q, a & 32'hffff_ffc0);
            wait_fill(1'b0);
            fetch(a | 32'h3c, 2'b10);
            fetch(a & 32'hffff_ffc0, 2'b10);
            fetch(a ^ 32'h1000, 2'b01);
            wait_fill(1'b0);
            fetch(a, 2'b01);
            wait_fill(1'b0);
        end
        d = $urandom & 32'h0000_07e0;
        for (i = 0; i < 6; i = i + 1) begin
            w = d | ((i == 1 || i == 5) ? 32'h800 : (i == 3) ? 32'h1000 : 32'h0);
            dacc(w, (i == 2 || i == 4) ? 3'b100 : 3'b010);
            if (i != 2 && i != 4) wait_fill(1'b1);
        end
        dacc(32'h8300_0040, 3'b001);
        wr(1'b0, 5'h13, 32'h1);
        rd(5'h13, 32'h1);
        dacc(32'h8300_0040, 3'b010);
        wait_fill(1'b1);
        dacc(32'h8300_0040, 3'b100);
        for (i = 0; i < 4; i = i + 1) begin
            slow = $urandom % 2;
            range_op(i, (i == 2) ? a : $urandom, 32'h1 + $urandom % 40);
        end
        fetch(a, 2'b01);
        wait_fill(1'b0);
        wr(1'b0, `TLC_IDX_WB_CNT, 32'h0);
        chk(busy, 1'b0);
        for (i = 0; i < 3; i = i + 1) begin
            w = (i == 0) ? 32'h0 : (i == 1) ? 32'h3 : 32'h7;
            wr(1'b0, `TLC_IDX_CFG, w);
            n0 = nacc;
            wr(1'b0, (i == 2) ? `TLC_IDX_FLUSH : `TLC_IDX_CLEAN, 32'h1);
            chk(busy, w != 0);
            wait_idle;
            chk(nacc - n0, SETS * ((w == 7) ? 4 : w));
        end
        report_and_stop;
    end
endmodule // two_level_cache_control_tb
